// ### logic/tds_consts.svh
// Constants of the temperature discharge sequencer.
// Assumes a 25 MHz system clock and a byte-addressed register port.
`ifndef TDS_CONSTS_SVH
`define TDS_CONSTS_SVH

// =====================================================================
// Register offsets
`define TDS_REG_CMD        8'h00
`define TDS_REG_CFG        8'h04
`define TDS_REG_IRQ_STAT   8'h08
`define TDS_REG_IRQ_MASK   8'h0C
`define TDS_REG_STATE      8'h10
`define TDS_REG_RES1       8'h14
`define TDS_REG_RES2       8'h18
`define TDS_REG_RES3       8'h1C
`define TDS_REG_RES4       8'h20

// =====================================================================
// Command bits
`define TDS_CMD_SINGLE     0
`define TDS_CMD_HOTCOLD    1

// Configuration fields
`define TDS_CFG_TWO_PORTS  0
`define TDS_CFG_ORDER      1
`define TDS_CFG_MAINS      2
`define TDS_CFG_STOPSEL    3
`define TDS_CFG_REFSEL     4
`define TDS_CFG_SUM_EN     5
`define TDS_CFG_FAKE       7:6
`define TDS_CFG_CYCLE      15:8
`define TDS_CFG_PAUSE      23:16
`define TDS_CFG_RESET      32'h0000_1000

// Interrupt event bits
`define TDS_EV_DONE        0
`define TDS_EV_TIMEOUT     1
`define TDS_EV_HOT_DONE    2
`define TDS_EV_SUM         3
`define TDS_EV_N           4

// =====================================================================
// Timing
`define TDS_CLK_PERIOD_NS  40
`define TDS_MAINS50_NS     20000000
`define TDS_MAINS60_NS     16670000
`define TDS_LAST_PORT4     2'h3
`define TDS_LAST_PORT2     2'h1
`define TDS_TIMER_MAX      16'hFFFF

`endif

// ### logic/tds_pkg.sv
// Types of the temperature discharge sequencer.
// Assumes tds_consts.svh holds the register, field and timing constants.
package tds_pkg;

	// =================================================================
	// Sequencer states
	typedef enum logic [1:0] {
		TDS_IDLE   = 2'b00,
		TDS_CHARGE = 2'b01,
		TDS_DISCH  = 2'b10,
		TDS_PAUSE  = 2'b11
	} tds_state_e;

	typedef logic [15:0] tds_time_t;

endpackage : tds_pkg

// ### logic/tds_sequencer.sv
// Temperature discharge sequencer: charges a load capacitor and times its
// discharge through up to four sensor ports, with single and hot/cold runs.
// Assumes comparator and reference clock pins are asynchronous, and the
// register master follows the one-cycle strobe protocol on i_clk.
// Results hold the last run only: hot results are read on the hot-done
// interrupt, during the pause. Pins must stay at each level two clocks at least.
//
// Functional notes
// RQ1: Hot/cold command runs the sequence twice.
// RQ2: Single command runs one sequence, then stops.
// RQ3: Pause between runs is count times mains period.
// RQ4: Two-port setting measures ports one and two.
// RQ5: Order set ascends ports, clear descends.
// RQ6: Cycle time bounds charge and discharge intervals.
// RQ7: Fake measurements precede real ones, results discarded.
// RQ8: Reference clock selection picks the timing source.
// RQ9: Stop comparator select: internal or external inverting.
// RQ10: Sum enable puts multihit sum in result four.
// RQ11: Host divides sum by number of hits.
// RQ12: Mains select: set 16.67 ms, clear 20 ms.
// RQ13: Results held and completion flagged after sequence.
//
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`include "tds_consts.svh"

module tds_sequencer
	import tds_pkg::*;
#(
	parameter int P_MAINS50_CYC = `TDS_MAINS50_NS / `TDS_CLK_PERIOD_NS, // 20 ms in cycles
	parameter int P_MAINS60_CYC = `TDS_MAINS60_NS / `TDS_CLK_PERIOD_NS  // 16.67 ms in cycles
) (
	input  wire logic        i_clk,        // System clock, 25 MHz
	input  wire logic        i_rst,        // Async reset, active high
	input  wire logic [7:0]  i_addr,       // Register byte address
	input  wire logic [31:0] i_wdata,      // Register write data
	input  wire logic        i_wr,         // Write strobe
	input  wire logic        i_rd,         // Read strobe
	output logic      [31:0] o_rdata,      // Read data, cycle after i_rd
	input  wire logic        i_ref_hs,     // High speed reference clock pin
	input  wire logic        i_ref_lf,     // Low frequency reference clock pin
	input  wire logic        i_cmp_int,    // Integrated comparator, high on stop
	input  wire logic        i_cmp_ext_n,  // External inverting comparator
	input  wire logic        i_mh_valid,   // Multihit results valid pulse
	input  wire logic [15:0] i_mh_hit1,    // First hit time
	input  wire logic [15:0] i_mh_hit2,    // Second hit time
	input  wire logic [15:0] i_mh_hit3,    // Third hit time
	output logic             o_charge,     // Charge the load capacitor
	output logic      [3:0]  o_port_en,    // Discharge through sensor port
	output logic             o_busy,       // Sequence running
	output logic             o_irq         // Interrupt, level
);

	// =================================================================
	// Pin synchronisers and edge detection
	localparam int N_PIN = 4;
	logic [N_PIN-1:0] pin_raw;
	logic [N_PIN-1:0] pin_s1;
	logic [N_PIN-1:0] pin_s2;
	logic [N_PIN-1:0] pin_s3;
	assign pin_raw = {i_cmp_ext_n, i_cmp_int, i_ref_lf, i_ref_hs};

	// The third flop turns each synchronised edge into a one-cycle pulse,
	// so a slow pin edge is counted once only
	genvar gi;
	generate
		for (gi = 0; gi < N_PIN; gi++) begin : g_sync
			// Two flops, then a third for edge detection
			always_ff @(posedge i_clk or posedge i_rst) begin
				if (i_rst) begin
					pin_s1[gi] <= 1'b0;
					pin_s2[gi] <= 1'b0;
					pin_s3[gi] <= 1'b0;
				end else begin
					pin_s1[gi] <= pin_raw[gi];
					pin_s2[gi] <= pin_s1[gi];
					pin_s3[gi] <= pin_s2[gi];
				end
			end
		end
	endgenerate

	// =================================================================
	// Configuration and software registers
	logic [31:0]           cfg;
	logic [`TDS_EV_N-1:0]  irq_stat;
	logic [`TDS_EV_N-1:0]  irq_mask;
	logic [`TDS_EV_N-1:0]  ev;
	tds_time_t             res [4];
	logic [17:0]           mh_sum;
	logic                  wr_cmd;
	logic                  start_single;
	logic                  start_hc;

	assign wr_cmd       = i_wr && (i_addr == `TDS_REG_CMD);
	assign start_single = wr_cmd && i_wdata[`TDS_CMD_SINGLE];
	assign start_hc     = wr_cmd && i_wdata[`TDS_CMD_HOTCOLD] && !i_wdata[`TDS_CMD_SINGLE];

	// Reference tick from the selected source
	// Stops are edge-detected, so a comparator left high by the last port is ignored
	logic ref_tick;
	logic stop_ev;
	always_comb begin
		if (cfg[`TDS_CFG_REFSEL])  // [RQ8]
			ref_tick = pin_s2[1] && !pin_s3[1];
		else
			ref_tick = pin_s2[0] && !pin_s3[0];
		if (cfg[`TDS_CFG_STOPSEL]) // [RQ9]
			stop_ev = !pin_s2[3] && pin_s3[3];
		else
			stop_ev = pin_s2[2] && !pin_s3[2];
	end

	// Configuration write
	// Takes effect at once; hosts should write it only while idle
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst)
			cfg <= `TDS_CFG_RESET;
		else if (i_wr && i_addr == `TDS_REG_CFG)
			cfg <= i_wdata;
	end

	// =================================================================
	// Sequencer
	tds_state_e state;
	logic       hotcold;
	logic       hot;
	logic [1:0] fake_left;
	logic [1:0] slot;
	logic [1:0] last_slot;
	logic [1:0] port_idx;
	logic [7:0] tick_cnt;
	logic [7:0] pause_cnt;
	logic [31:0] mains_cnt;
	logic [31:0] mains_last;
	tds_time_t  timer;
	logic       meas_end;
	logic       run_end;

	// Two-port mode shortens the scan
	assign last_slot = cfg[`TDS_CFG_TWO_PORTS] ? `TDS_LAST_PORT2 : `TDS_LAST_PORT4; // [RQ4]
	// Fakes use the first port of the order
	always_comb begin
		if (fake_left != 2'h0)
			port_idx = cfg[`TDS_CFG_ORDER] ? 2'h0 : last_slot;
		else if (cfg[`TDS_CFG_ORDER])  // [RQ5]
			port_idx = slot;
		else
			port_idx = last_slot - slot;
	end

	// Discharge ends on stop or after one cycle time of reference ticks
	assign meas_end = (state == TDS_DISCH) &&
		(stop_ev || (ref_tick && tick_cnt == cfg[`TDS_CFG_CYCLE])); // [RQ6]
	// A run ends on its last real port; fakes never end a run
	assign run_end  = meas_end && fake_left == 2'h0 && slot == last_slot;
	// Mains period as a cycle count
	assign mains_last = cfg[`TDS_CFG_MAINS] ? P_MAINS60_CYC - 1 : P_MAINS50_CYC - 1; // [RQ12]

	// State and sequence position
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state     <= TDS_IDLE;
			hotcold   <= 1'b0;
			hot       <= 1'b0;
			fake_left <= 2'h0;
			slot      <= 2'h0;
		end else begin
			unique case (state)
				// Commands arriving while busy are ignored
				TDS_IDLE: begin
					if (start_single || start_hc) begin
						state     <= TDS_CHARGE;
						hotcold   <= start_hc;                  // [RQ1]
						hot       <= 1'b1;
						fake_left <= cfg[`TDS_CFG_FAKE];        // [RQ7]
						slot      <= 2'h0;
					end
				end
				// Charge for one cycle time of reference ticks
				TDS_CHARGE: begin
					if (ref_tick && tick_cnt == cfg[`TDS_CFG_CYCLE])
						state <= TDS_DISCH;                     // [RQ6]
				end
				// Fakes first, then real ports, then the cold run or idle
				TDS_DISCH: begin
					if (meas_end) begin
						if (fake_left != 2'h0) begin
							fake_left <= fake_left - 2'h1;      // [RQ7]
							state     <= TDS_CHARGE;
						end else if (slot != last_slot) begin
							slot  <= slot + 2'h1;
							state <= TDS_CHARGE;
						end else if (hotcold && hot) begin
							// Cold run follows after the pause
							hot       <= 1'b0;                  // [RQ1]
							slot      <= 2'h0;
							fake_left <= cfg[`TDS_CFG_FAKE];
							state     <= (cfg[`TDS_CFG_PAUSE] == 8'h00) ? TDS_CHARGE : TDS_PAUSE;
						end else begin
							state <= TDS_IDLE;                  // [RQ2]
						end
					end
				end
				// Count mains periods, then the cold run charges again
				TDS_PAUSE: begin
					if (mains_cnt == mains_last && pause_cnt == cfg[`TDS_CFG_PAUSE] - 8'h01)
						state <= TDS_CHARGE;                    // [RQ3]
				end
			endcase
		end
	end

	// Reference tick counter for charge and discharge windows
	// Restarts at every port, so each window spans one full cycle time
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst)
			tick_cnt <= 8'h00;
		else if (state == TDS_IDLE || state == TDS_PAUSE || meas_end)
			tick_cnt <= 8'h00;
		else if (ref_tick)
			tick_cnt <= (tick_cnt == cfg[`TDS_CFG_CYCLE]) ? 8'h00 : tick_cnt + 8'h01;
	end

	// Pause counter: mains periods times pause count
	// The mains count is an enable divider; the pause count steps once per period
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			mains_cnt <= 32'h0000_0000;
			pause_cnt <= 8'h00;
		end else if (state != TDS_PAUSE) begin
			mains_cnt <= 32'h0000_0000;
			pause_cnt <= 8'h00;
		end else if (mains_cnt == mains_last) begin
			mains_cnt <= 32'h0000_0000;
			pause_cnt <= pause_cnt + 8'h01;                     // [RQ3]
		end else begin
			mains_cnt <= mains_cnt + 32'h0000_0001;
		end
	end

	// Discharge timer in system clocks, saturating
	// Saturates rather than wraps, so a very slow discharge reads as full scale
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst)
			timer <= 16'h0000;
		else if (state != TDS_DISCH)
			timer <= 16'h0000;
		else if (timer != `TDS_TIMER_MAX)
			timer <= timer + 16'h0001;
	end

	// =================================================================
	// Results
	// One result register per port; fake measurements never overwrite one
	genvar gp;
	generate
		for (gp = 0; gp < 4; gp++) begin : g_res
			always_ff @(posedge i_clk or posedge i_rst) begin
				if (i_rst) begin
					res[gp] <= 16'h0000;
				end else if (meas_end && fake_left == 2'h0 && port_idx == 2'(gp)) begin
					// Raw discharge time, or full scale on timeout
					res[gp] <= stop_ev ? timer : `TDS_TIMER_MAX; // [RQ13]
				end
			end
		end
	endgenerate

	// Multihit sum; host divides it by the number of hits
	// Eighteen bits, so three full-scale hits cannot overflow
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst)
			mh_sum <= 18'h0_0000;
		else if (i_mh_valid && cfg[`TDS_CFG_SUM_EN])
			mh_sum <= {2'b00, i_mh_hit1} + {2'b00, i_mh_hit2} + {2'b00, i_mh_hit3}; // [RQ10]
	end

	// =================================================================
	// Interrupts: sticky, write one to clear, set wins
	// Event pulses, one cycle each
	always_comb begin
		ev                   = '0;
		ev[`TDS_EV_DONE]     = run_end && !(hotcold && hot);    // [RQ13]
		ev[`TDS_EV_TIMEOUT]  = meas_end && !stop_ev;
		ev[`TDS_EV_HOT_DONE] = run_end && hotcold && hot;
		ev[`TDS_EV_SUM]      = i_mh_valid && cfg[`TDS_CFG_SUM_EN];
	end

	// Status: an event in the clearing cycle wins over the clear
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst)
			irq_stat <= '0;
		else if (i_wr && i_addr == `TDS_REG_IRQ_STAT)
			irq_stat <= (irq_stat & ~i_wdata[`TDS_EV_N-1:0]) | ev;
		else
			irq_stat <= irq_stat | ev;
	end

	// Mask, same layout as the status
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst)
			irq_mask <= '0;
		else if (i_wr && i_addr == `TDS_REG_IRQ_MASK)
			irq_mask <= i_wdata[`TDS_EV_N-1:0];
	end

	assign o_irq = |(irq_stat & irq_mask);

	// =================================================================
	// Read port, data one cycle after the strobe
	// Zero outside the answer cycle, so a stale word never lingers
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_rdata <= 32'h0000_0000;
		end else if (i_rd) begin
			unique case (i_addr)
				`TDS_REG_CFG:      o_rdata <= cfg;
				`TDS_REG_IRQ_STAT: o_rdata <= {28'h000_0000, irq_stat};
				`TDS_REG_IRQ_MASK: o_rdata <= {28'h000_0000, irq_mask};
				`TDS_REG_STATE:    o_rdata <= {24'h00_0000, port_idx, slot, hot, hotcold, state};
				`TDS_REG_RES1:     o_rdata <= {16'h0000, res[0]};
				`TDS_REG_RES2:     o_rdata <= {16'h0000, res[1]};
				`TDS_REG_RES3:     o_rdata <= {16'h0000, res[2]};
				`TDS_REG_RES4:     o_rdata <= cfg[`TDS_CFG_SUM_EN] ?
					{14'h0000, mh_sum} : {16'h0000, res[3]};        // [RQ10]
				default:           o_rdata <= 32'h0000_0000;
			endcase
		end else begin
			o_rdata <= 32'h0000_0000;
		end
	end

	// =================================================================
	// Pin drive decoded from state flops
	// Charge and discharge are exclusive by state, so the capacitor is never
	// charged while a sensor port draws from it
	assign o_charge = (state == TDS_CHARGE);
	assign o_busy   = (state != TDS_IDLE);
	always_comb begin
		o_port_en = 4'h0;
		if (state == TDS_DISCH)
			o_port_en[port_idx] = 1'b1;
	end

endmodule : tds_sequencer

// ### tb/tds_sensor_model.sv
// Sensors and load capacitor behind the sequencer's discharge pins.
// Assumes one port is opened at a time and that charging closes it.
`timescale 1ns/1ps
module tds_sensor_model (
	input  wire logic       i_clk,       // System clock
	input  wire logic [3:0] i_port_en,   // Port discharging
	input  wire logic       i_slow,      // Never stop, forces a timeout
	output logic            o_ref_hs,    // Fast reference clock
	output logic            o_ref_lf,    // Slow reference clock
	output logic            o_cmp_int,   // Comparator, high on stop
	output logic            o_cmp_ext_n  // Inverting comparator, six clocks late
);
	// =========================================================
	// Free running references, comparators idle at start
	initial begin
		o_cmp_int = 1'b0;
		o_cmp_ext_n = 1'b1;
		o_ref_hs = 1'b0;
		forever #80 o_ref_hs = ~o_ref_hs;
	end
	initial begin
		o_ref_lf = 1'b0;
		forever #200 o_ref_lf = ~o_ref_lf;
	end
	// Discharge time grows with the port number
	logic [7:0] cnt;
	logic [7:0] dly;
	assign dly = i_port_en[0] ? 8'h08 : i_port_en[1] ? 8'h0C : i_port_en[2] ? 8'h10 : 8'h14;
	always @(posedge i_clk) begin
		cnt <= (i_port_en == 4'h0) ? 8'h00 : cnt + 8'h01;
		o_cmp_int <= !i_slow && cnt >= dly;
		o_cmp_ext_n <= !(!i_slow && cnt >= dly + 8'h06);
	end
endmodule : tds_sensor_model

// ### tb/tds_sequencer_props.sv
// Port checker of the temperature discharge sequencer.
// Assumes the register map of tds_consts.svh.
`timescale 1ns/1ps
`include "tds_consts.svh"
module tds_sequencer_props (
	input wire logic        i_clk,     // Clock
	input wire logic        i_rst,     // Reset
	input wire logic [7:0]  i_addr,    // Address
	input wire logic [31:0] i_wdata,   // Write data
	input wire logic        i_wr,      // Write strobe
	input wire logic        i_rd,      // Read strobe
	input wire logic [31:0] o_rdata,   // Read data
	input wire logic        o_charge,  // Charging
	input wire logic [3:0]  o_port_en, // Port open
	input wire logic        o_busy,    // Running
	input wire logic        o_irq      // Interrupt
);
	// =========================================================
	// Assertions
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	charge_alone_a: assert property (o_charge |-> o_port_en == 4'h0)
		else $error("charge with port open");
	port_onehot_a: assert property ($onehot0(o_port_en))
		else $error("two ports open");
	busy_span_a: assert property ((o_charge || o_port_en != 4'h0) |-> o_busy)
		else $error("activity while idle");
	rdata_quiet_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0000_0000)
		else $error("read data without read");
	unmapped_zero_a: assert property (i_rd && i_addr > 8'h20 |=> o_rdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	mask_off_a: assert property (i_wr && i_addr == `TDS_REG_IRQ_MASK && i_wdata == 32'h0 |=> !o_irq)
		else $error("masked interrupt high");
	start_run_a: assert property (i_wr && i_addr == `TDS_REG_CMD && i_wdata[1:0] != 2'h0 && !o_busy
		|=> o_busy && o_charge)
		else $error("command did not start");
	disch_next_a: assert property ($fell(o_charge) && o_busy |-> o_port_en != 4'h0)
		else $error("no discharge after charge");
	port_hold_a: assert property (o_port_en != 4'h0 |=> o_port_en == $past(o_port_en) || o_port_en == 4'h0)
		else $error("port switched mid discharge");
	cover property (o_port_en[3] ##1 o_port_en == 4'h0);
	cover property ($fell(o_busy));
	cover property (o_irq);
endmodule : tds_sequencer_props

bind tds_sequencer tds_sequencer_props tds_sequencer_props_i (.*);

// ### tb/tds_sequencer_tb.sv
// Self-checking bench of the temperature discharge sequencer.
// Assumes the sensor model answers port k after 4k+4 clocks.
`timescale 1ns/1ps
`include "tds_consts.svh"
module tds_sequencer_tb;
	typedef struct {logic [31:0] cfg, cmd, hist, gap, res, stat;} tds_row_s;
	logic i_clk, i_rst, i_wr, i_rd, i_mh_valid, ref_hs, ref_lf, cmp_i, cmp_n, slow, irq_s;
	logic o_charge, o_busy, o_irq;
	logic [7:0] i_addr;
	logic [31:0] i_wdata, o_rdata, v, hist, maxgap, gap;
	logic [15:0] i_mh_hit1, i_mh_hit2, i_mh_hit3;
	logic [3:0] o_port_en, pe_q;
	int failures, tests_run, cyc;
	tds_row_s rows [8] = '{
		'{32'h0000_1002, 1, 32'h1248, 0, 8, 1},
		'{32'h0000_1000, 1, 32'h8421, 0, 8, 1},
		'{32'h0000_1043, 1, 32'h0112, 0, 8, 1},
		'{32'h0000_1081, 1, 32'h2221, 0, 8, 1},
		'{32'h0000_1012, 1, 32'h1248, 0, 8, 1},
		'{32'h0000_100A, 1, 32'h1248, 0, 14, 1},
		'{32'h0002_1003, 2, 32'h1212, 40, 8, 5},
		'{32'h0002_1007, 2, 32'h1212, 34, 8, 5}};
	tds_sequencer #(.P_MAINS50_CYC(20), .P_MAINS60_CYC(17)) tds_sequencer_i (.i_clk(i_clk),
		.i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .i_ref_hs(ref_hs), .i_ref_lf(ref_lf), .i_cmp_int(cmp_i),
		.i_cmp_ext_n(cmp_n), .i_mh_valid(i_mh_valid), .i_mh_hit1(i_mh_hit1),
		.i_mh_hit2(i_mh_hit2), .i_mh_hit3(i_mh_hit3), .o_charge(o_charge),
		.o_port_en(o_port_en), .o_busy(o_busy), .o_irq(o_irq));
	tds_sensor_model tds_sensor_model_i (.i_clk(i_clk), .i_port_en(o_port_en), .i_slow(slow),
		.o_ref_hs(ref_hs), .o_ref_lf(ref_lf), .o_cmp_int(cmp_i), .o_cmp_ext_n(cmp_n));
	// =========================================================
	// Clock, port history, pause length and timeout
	initial begin
		i_clk = 1'b0;
		forever #20 i_clk = ~i_clk;
	end
	always @(negedge i_clk) irq_s = o_irq;
	always @(posedge i_clk) begin
		pe_q <= o_port_en;
		if (o_port_en != 4'h0 && pe_q == 4'h0) hist <= {hist[27:0], o_port_en};
		gap <= (o_busy && !o_charge && o_port_en == 4'h0) ? gap + 1 : 0;
		if (gap > maxgap) maxgap <= gap;
		cyc++;
		if (cyc == 40000) begin
			failures++;
			wrap_up;
		end
	end
	// Bus cycles, waits and compares
	task wr(input logic [7:0] a, input logic [31:0] d);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
		@(posedge i_clk);
	endtask : wr
	task rd(input logic [7:0] a);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 v = o_rdata;
		@(posedge i_clk);
	endtask : rd
	task wait_idle;
		do @(negedge i_clk); while (o_busy !== 1'b0);
		@(posedge i_clk);
	endtask : wait_idle
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task chkr(input string n, input logic [31:0] lo, input logic [31:0] g);
		tests_run++;
		if ((g >= lo && g <= lo + 6) !== 1'b1) begin
			failures++;
			$display("Error %s expected %h to %h seen %h", n, lo, lo + 6, g);
		end
	endtask : chkr
	task wrap_up;
		if (failures == 0 && tests_run > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : wrap_up
	// Reset, table of runs, then timeout and multihit sum
	initial begin
		i_rst = 1'b1;
		{i_addr, i_wdata, i_wr, i_rd, i_mh_valid, slow} = '0;
		{i_mh_hit1, i_mh_hit2, i_mh_hit3, hist, maxgap, gap, pe_q} = 0;
		repeat (10) @(posedge i_clk);
		i_rst <= 1'b0;
		@(posedge i_clk);
		rd(`TDS_REG_CFG);
		chk("cfg reset", `TDS_CFG_RESET, v);
		rd(8'h24);
		chk("unmapped", 0, v);
		wr(`TDS_REG_IRQ_MASK, 32'h0000_000F);
		foreach (rows[i]) begin
			wr(`TDS_REG_CFG, rows[i].cfg);
			hist = 0;
			maxgap = 0;
			wr(`TDS_REG_CMD, rows[i].cmd);
			wait_idle;
			chk("port order", rows[i].hist, hist);
			chkr("pause", rows[i].gap, maxgap);
			rd(`TDS_REG_RES1);
			chkr("result", rows[i].res, v);
			rd(`TDS_REG_IRQ_STAT);
			chk("status", rows[i].stat, v);
			chk("irq", 1, {31'h0, irq_s});
			wr(`TDS_REG_IRQ_STAT, 32'h0000_000F);
			chk("irq clear", 0, {31'h0, irq_s});
		end
		slow <= 1'b1;
		wr(`TDS_REG_CFG, 32'h0000_1023);
		wr(`TDS_REG_CMD, 1);
		wait_idle;
		rd(`TDS_REG_RES1);
		chk("timeout", 32'h0000_FFFF, v);
		rd(`TDS_REG_IRQ_STAT);
		chk("timeout flag", 32'h0000_0003, v);
		{i_mh_hit1, i_mh_hit2, i_mh_hit3} <= {16'hFFFF, 16'hFFFF, 16'h0002};
		i_mh_valid <= 1'b1;
		@(posedge i_clk);
		i_mh_valid <= 1'b0;
		@(posedge i_clk);
		rd(`TDS_REG_RES4);
		chk("sum", 32'h0002_0000, v);
		chk("sum mean", 32'h0000_AAAA, v / 3);
		wr(`TDS_REG_IRQ_MASK, 0);
		chk("masked", 0, {31'h0, irq_s});
		wr(`TDS_REG_CMD, 1);
		repeat (4) @(posedge i_clk);
		i_rst <= 1'b1;
		@(negedge i_clk);
		chk("reset outputs", 0, {26'h0, o_charge, o_busy, o_port_en});
		@(posedge i_clk);
		i_rst <= 1'b0;
		@(posedge i_clk);
		rd(`TDS_REG_CFG);
		chk("cfg after reset", `TDS_CFG_RESET, v);
		wrap_up;
	end
endmodule : tds_sequencer_tb
